//--- src/asf_frame_sequencer.sv
// Frame sequencer of a multichannel audio serial port with a Wishbone slave
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "asf_defines.svh"
// How it works
// - Shared mode: receive runs on transmit bit clock and transmit frame sync
// - Shared mode: receive sync generator off, receive sync pin not driven
// - Independent mode: each section has its own bit clock and sync
// - Burst: sync is data driven, one sync per word
// - Burst: one slot per sync edge, later clocks ignored
// - Burst: first data bit 0 to 3 bit clocks after sync edge
// - Burst: sync lasts one bit clock, width settings zero
// - Internal burst transmit sync waits for idle and all buffers written
// - Internal burst receive sync waits for idle and all buffers read
// - Slotted frames hold 1 to 511 slots, each maskable
// - Separate slot counters start at sync and consult their masks
// - Disabled slot: no buffer update, no event
// - Disabled slot: transmitter pin idles hi-z, low or high per setting
// - Request for active slot N raised at first bit of slot N-1
// - Next slot disabled: request deferred to first bit of slot M-1
// - Receive request only after copy into buffer; none for disabled slot
// - Receive supports 384-slot frames; slot N enabled by receive mask bit N mod 32
module asf_frame_sequencer
  import asf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic txBitclkPin,
  input wire logic rxBitclkPin,
  input wire logic txFramesyncPinIn,
  output logic txFramesyncPinOut,
  output logic txFramesyncPinOe_b,
  input wire logic rxFramesyncPinIn,
  output logic rxFramesyncPinOut,
  output logic rxFramesyncPinOe_b,
  input wire logic [1:0] serialDataPinIn,
  output logic [1:0] serialDataPinOut,
  output logic [1:0] serialDataPinOe_b,
  output logic txDataRequest,
  output logic rxDataRequest
);
  asf_state_t s, n;
  logic indep, txTick, rxTick, txFs, rxFs, txEdge, rxEdge, txBurst, rxBurst;

  function automatic logic lastSlot(logic [8:0] slot, logic [8:0] cnt);
    return (slot + 9'h1) >= cnt;
  endfunction

  function automatic logic [1:0] serMode(logic [7:0] c, int i);
    return c[i * `ASF_SER_STRIDE +: 2];
  endfunction

  function automatic logic [1:0] serIdle(logic [7:0] c, int i);
    return c[i * `ASF_SER_STRIDE + `ASF_SER_IDLEPOS +: 2];
  endfunction

  // Advance a slot sequencer by one bit clock
  function automatic asf_seq_t seqStep(asf_seq_t q, logic fsEdge,
      logic [1:0] dly, logic [4:0] sz, logic [8:0] cnt);
    asf_seq_t r;
    r = q;
    if (fsEdge) begin
      r.slot = '0;
      r.bitCnt = '0;
      r.dly = dly - 2'h1;
      r.phase = (dly == 2'h0) ? ASF_SHIFT : ASF_DELAY;
    end else if (q.phase == ASF_DELAY) begin
      r.dly = q.dly - 2'h1;
      if (q.dly == 2'h0) r.phase = ASF_SHIFT;
    end else if (q.phase == ASF_SHIFT) begin
      r.bitCnt = q.bitCnt + 5'h1;
      if (q.bitCnt == sz) begin
        r.bitCnt = '0;
        r.slot = q.slot + 9'h1;
        if (lastSlot(q.slot, cnt)) r.phase = ASF_IDLE;
      end
    end
    return r;
  endfunction

  // Internal frame sync: returns {sync level, frame bit counter}
  function automatic logic [14:0] fsGen(logic en, logic [8:0] cnt,
      logic [4:0] sz, logic wid, logic idle, logic pend, logic fs,
      logic [13:0] fc);
    logic [13:0] len;
    logic [13:0] f;
    len = 14'({5'h0, cnt} * ({9'h0, sz} + 14'h1));
    f = (fc + 14'h1 >= len) ? 14'h0 : fc + 14'h1;
    if (!en) return 15'h0;
    if (cnt == `ASF_BURST) return {~fs & idle & ~pend, 14'h0};
    return {(fc == 14'h0) | (wid & (fc <= {9'h0, sz})), f};
  endfunction

  function automatic logic [31:0] rdWord(asf_state_t q, logic [7:0] a);
    logic [31:0] r;
    r = '0;
    if (a == `ASF_A_CTRL) begin
      r[`ASF_C_ALL] = q.ctrl;
    end else if (a == `ASF_A_TXFMT) begin
      r[`ASF_F_SIZE] = q.txSize;
      r[`ASF_F_COUNT] = q.txCount;
    end else if (a == `ASF_A_RXFMT) begin
      r[`ASF_F_SIZE] = q.rxSize;
      r[`ASF_F_COUNT] = q.rxCount;
    end else if (a == `ASF_A_TXMASK) begin
      r = q.txMask;
    end else if (a == `ASF_A_RXMASK) begin
      r = q.rxMask;
    end else if (a == `ASF_A_SERCTL) begin
      r[`ASF_SER_ALL] = q.serCtl;
    end else if (a == `ASF_A_STAT) begin
      r[`ASF_S_TXSLOT] = q.tx.slot;
      r[`ASF_S_TXREQ] = q.txPend;
      r[`ASF_S_RXREQ] = q.rxPend;
      r[`ASF_S_RXSLOT] = q.rx.slot;
    end else if ((a & ~`ASF_A_BUFSEL) == `ASF_A_TXBUF0) begin
      r = q.txBuf[a[`ASF_A_BUFIDX]];
    end else if ((a & ~`ASF_A_BUFSEL) == `ASF_A_RXBUF0) begin
      r = q.rxBuf[a[`ASF_A_BUFIDX]];
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d,
      logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b * 8 +: 8] = d[b * 8 +: 8];
    end
    return r;
  endfunction

  assign indep = s.ctrl[`ASF_C_INDEP];
  assign txBurst = s.txCount == `ASF_BURST;
  assign rxBurst = s.rxCount == `ASF_BURST;
  assign txTick = s.syncB[0] & ~s.txClkPrev;
  assign rxTick = indep ? (s.syncB[1] & ~s.rxClkPrev) : txTick;
  assign txFs = s.ctrl[`ASF_C_TXFSINT] ? s.txFsOut : s.syncB[2];
  assign rxFs = !indep ? txFs :
      (s.ctrl[`ASF_C_RXFSINT] ? s.rxFsOut : s.syncB[3]);
  assign txEdge = txTick & txFs & ~s.txFsPrev;
  assign rxEdge = rxTick & rxFs & ~s.rxFsPrev;

  always_comb begin
    logic [31:0] w;
    logic [31:0] v;
    logic [8:0] nx;
    logic [1:0] txSer;
    logic [1:0] rxSer;
    w = '0;
    v = '0;
    nx = '0;
    txSer = '0;
    rxSer = '0;
    n = s;
    n.syncA = {serialDataPinIn, rxFramesyncPinIn, txFramesyncPinIn,
               rxBitclkPin, txBitclkPin};
    n.syncB = s.syncA;
    n.txClkPrev = s.syncB[0];
    n.rxClkPrev = s.syncB[1];
    // Bus: data latched when taken, writes commit at the ack edge
    n.ack = cyc_i & stb_i & ~s.ack;
    if (n.ack) n.dat = rdWord(s, adr_i);
    if (cyc_i & stb_i & s.ack) begin
      w = merge(rdWord(s, adr_i), dat_i, sel_i);
      if (!we_i) begin
        if ((adr_i & ~`ASF_A_BUFSEL) == `ASF_A_RXBUF0) begin
          n.rxRd[adr_i[`ASF_A_BUFIDX]] = 1'b1;
        end
      end else if (adr_i == `ASF_A_CTRL) begin
        n.ctrl = w[`ASF_C_ALL];
        if (w[`ASF_C_TXEN] & ~s.ctrl[`ASF_C_TXEN]) begin
          n.txPend = 1'b1;
          n.txWr = '0;
        end
      end else if (adr_i == `ASF_A_TXFMT) begin
        n.txSize = w[`ASF_F_SIZE];
        n.txCount = w[`ASF_F_COUNT];
      end else if (adr_i == `ASF_A_RXFMT) begin
        n.rxSize = w[`ASF_F_SIZE];
        n.rxCount = w[`ASF_F_COUNT];
      end else if (adr_i == `ASF_A_TXMASK) begin
        n.txMask = w;
      end else if (adr_i == `ASF_A_RXMASK) begin
        n.rxMask = w;
      end else if (adr_i == `ASF_A_SERCTL) begin
        n.serCtl = w[`ASF_SER_ALL];
      end else if ((adr_i & ~`ASF_A_BUFSEL) == `ASF_A_TXBUF0) begin
        n.txBuf[adr_i[`ASF_A_BUFIDX]] = w;
        n.txWr[adr_i[`ASF_A_BUFIDX]] = 1'b1;
      end
    end
    for (int i = 0; i < `ASF_NSER; i++) begin
      txSer[i] = serMode(s.serCtl, i) == `ASF_SER_TX;
      rxSer[i] = serMode(s.serCtl, i) == `ASF_SER_RX;
    end
    // Requests drop once every buffer of the section is serviced
    if ((n.txWr | ~txSer) == 2'h3) n.txPend = 1'b0;
    if ((n.rxRd | ~rxSer) == 2'h3) n.rxPend = 1'b0;
    // Transmit section, one step per bit clock
    if (txTick) begin
      n.txFsPrev = txFs;
      n.tx = seqStep(s.tx, txEdge & s.ctrl[`ASF_C_TXEN],
          s.ctrl[`ASF_C_TXDLY], s.txSize, s.txCount);
      {n.txFsOut, n.txFc} = fsGen(
          s.ctrl[`ASF_C_TXEN] & s.ctrl[`ASF_C_TXFSINT], s.txCount,
          s.txSize, s.ctrl[`ASF_C_TXFSW], s.tx.phase == ASF_IDLE,
          s.txPend, s.txFsOut, s.txFc);
      if (n.tx.phase == ASF_SHIFT && n.tx.bitCnt == 5'h0) begin
        n.txAct = s.txMask[n.tx.slot[`ASF_SLOT_IDX]];
        nx = lastSlot(n.tx.slot, s.txCount) ? 9'h0 : n.tx.slot + 9'h1;
        if (s.txMask[nx[`ASF_SLOT_IDX]]) begin
          n.txPend = 1'b1;
          n.txWr = '0;
        end
        for (int i = 0; i < `ASF_NSER; i++) begin
          if (n.txAct) n.txSh[i] = s.txBuf[i] << (`ASF_MAXBIT - s.txSize);
        end
      end else begin
        n.txAct = s.txAct & (n.tx.phase == ASF_SHIFT);
        for (int i = 0; i < `ASF_NSER; i++) begin
          n.txSh[i] = {s.txSh[i][30:0], 1'b0};
        end
      end
    end
    for (int i = 0; i < `ASF_NSER; i++) begin
      if (serMode(n.serCtl, i) != `ASF_SER_TX) begin
        n.serOut[i] = 1'b0;
        n.serOe_b[i] = 1'b1;
      end else if (n.txAct) begin
        n.serOut[i] = n.txSh[i][31];
        n.serOe_b[i] = 1'b0;
      end else begin
        n.serOut[i] = serIdle(n.serCtl, i) == `ASF_IDLE_HIGH;
        n.serOe_b[i] = serIdle(n.serCtl, i) != `ASF_IDLE_HIGH &&
                       serIdle(n.serCtl, i) != `ASF_IDLE_LOW;
      end
    end
    // Receive section, one step per bit clock
    if (rxTick) begin
      n.rxFsPrev = rxFs;
      for (int i = 0; i < `ASF_NSER; i++) begin
        if (rxSer[i] && s.rx.phase == ASF_SHIFT) begin
          v = {s.rxSh[i][30:0], s.syncB[`ASF_SYNC_DIN + i]};
          n.rxSh[i] = v;
          if (s.rx.bitCnt == s.rxSize &&
              s.rxMask[s.rx.slot[`ASF_SLOT_IDX]]) begin
            n.rxBuf[i] = v & ~(32'hffff_fffe << s.rxSize);
            n.rxPend = 1'b1;
            n.rxRd = '0;
          end
        end
      end
      n.rx = seqStep(s.rx, rxEdge & s.ctrl[`ASF_C_RXEN],
          s.ctrl[`ASF_C_RXDLY], s.rxSize, s.rxCount);
      if (indep) begin
        {n.rxFsOut, n.rxFc} = fsGen(
            s.ctrl[`ASF_C_RXEN] & s.ctrl[`ASF_C_RXFSINT], s.rxCount,
            s.rxSize, s.ctrl[`ASF_C_RXFSW], s.rx.phase == ASF_IDLE,
            s.rxPend, s.rxFsOut, s.rxFc);
      end else begin
        n.rxFsOut = 1'b0;
        n.rxFc = '0;
      end
    end
    // Shared mode never leaves a stale receive sync standing
    if (!n.ctrl[`ASF_C_INDEP]) n.rxFsOut = 1'b0;
    n.txFsOe_b = ~n.ctrl[`ASF_C_TXFSINT];
    n.rxFsOe_b = ~(n.ctrl[`ASF_C_INDEP] & n.ctrl[`ASF_C_RXFSINT]);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.txSize <= `ASF_RST_SIZE;
      s.rxSize <= `ASF_RST_SIZE;
      s.txMask <= `ASF_RST_MASK;
      s.rxMask <= `ASF_RST_MASK;
      s.txFsOe_b <= 1'b1;
      s.rxFsOe_b <= 1'b1;
      s.serOe_b <= 2'h3;
    end else begin
      s <= n;
    end
  end

  assign dat_o = s.dat;
  assign ack_o = s.ack;
  assign txFramesyncPinOut = s.txFsOut;
  assign txFramesyncPinOe_b = s.txFsOe_b;
  assign rxFramesyncPinOut = s.rxFsOut;
  assign rxFramesyncPinOe_b = s.rxFsOe_b;
  assign serialDataPinOut = s.serOut;
  assign serialDataPinOe_b = s.serOe_b;
  assign txDataRequest = s.txPend;
  assign rxDataRequest = s.rxPend;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_SHARED_NO_RX_SYNC: assert property (
      !indep |=> s.rxFsOe_b && !s.rxFsOut)
    else $error("receive sync pin active in shared mode");
  AST_SHARED_CLOCK: assert property (!indep && rxTick |-> txTick)
    else $error("receive stepped without transmit bit clock");
  AST_BURST_ONE_SLOT: assert property (
      txTick && txBurst && !txEdge && s.tx.phase == ASF_SHIFT &&
      s.tx.bitCnt == s.txSize |=> s.tx.phase == ASF_IDLE)
    else $error("burst did not stop after one slot");
  AST_SYNC_ONE_BIT: assert property (
      txTick && txBurst && s.txFsOut |=> !s.txFsOut)
    else $error("burst sync longer than one bit clock");
  AST_TX_SYNC_GATE: assert property (
      $rose(s.txFsOut) && txBurst |-> !$past(s.txPend) &&
      $past(s.tx.phase) == ASF_IDLE)
    else $error("transmit sync before buffers were filled");
  AST_RX_SYNC_GATE: assert property (
      $rose(s.rxFsOut) && rxBurst |-> !$past(s.rxPend))
    else $error("receive sync before buffers were read");
  AST_SLOT_RESTART: assert property (
      txEdge && s.ctrl[`ASF_C_TXEN] |=> s.tx.slot == 9'h0)
    else $error("slot counter not restarted by sync");
  AST_DELAY_TWO: assert property (
      txEdge && s.ctrl[`ASF_C_TXEN] && s.ctrl[`ASF_C_TXDLY] == 2'h2
      |=> s.tx.phase == ASF_DELAY)
    else $error("two-bit delay not applied");
  AST_IDLE_PIN: assert property (
      serMode(s.serCtl, 0) == `ASF_SER_TX && !s.txAct &&
      serIdle(s.serCtl, 0) == `ASF_IDLE_HIGH |-> s.serOut[0] && !s.serOe_b[0])
    else $error("idle level wrong in disabled slot");
  AST_RX_NO_EVENT: assert property (
      rxTick && !s.rxPend && s.rx.phase == ASF_SHIFT &&
      !s.rxMask[s.rx.slot[`ASF_SLOT_IDX]] |=> !s.rxPend)
    else $error("request raised for disabled receive slot");

  CV_TX_BURST: cover property ($rose(s.txFsOut) && txBurst);
  CV_RX_COPY: cover property ($rose(s.rxPend));
  CV_TX_SLOTTED_REQ: cover property ($rose(s.txPend) && !txBurst);
endmodule // asf_frame_sequencer
`default_nettype wire

//--- src/asf_defines.svh
// Register map, field positions and reset values of the frame sequencer
`ifndef ASF_DEFINES_SVH
`define ASF_DEFINES_SVH
`define ASF_NSER 2
`define ASF_A_CTRL 8'h00
`define ASF_A_TXFMT 8'h04
`define ASF_A_RXFMT 8'h08
`define ASF_A_TXMASK 8'h0c
`define ASF_A_RXMASK 8'h10
`define ASF_A_SERCTL 8'h14
`define ASF_A_STAT 8'h18
`define ASF_A_TXBUF0 8'h20
`define ASF_A_RXBUF0 8'h28
`define ASF_A_BUFSEL 8'h04
`define ASF_A_BUFIDX 2
`define ASF_C_ALL 10:0
`define ASF_C_INDEP 0
`define ASF_C_TXEN 1
`define ASF_C_RXEN 2
`define ASF_C_TXFSINT 3
`define ASF_C_RXFSINT 4
`define ASF_C_TXFSW 5
`define ASF_C_RXFSW 6
`define ASF_C_TXDLY 8:7
`define ASF_C_RXDLY 10:9
`define ASF_F_SIZE 4:0
`define ASF_F_COUNT 24:16
`define ASF_SER_ALL 7:0
`define ASF_SER_STRIDE 4
`define ASF_SER_IDLEPOS 2
`define ASF_S_TXSLOT 8:0
`define ASF_S_TXREQ 9
`define ASF_S_RXREQ 10
`define ASF_S_RXSLOT 24:16
`define ASF_SLOT_IDX 4:0
`define ASF_SYNC_DIN 4
`define ASF_SER_TX 2'h1
`define ASF_SER_RX 2'h2
`define ASF_IDLE_LOW 2'h2
`define ASF_IDLE_HIGH 2'h3
`define ASF_BURST 9'h000
`define ASF_MAXBIT 5'h1f
`define ASF_RST_SIZE 5'h1f
`define ASF_RST_MASK 32'h0000_0001
`endif

//--- src/asf_pkg.sv
// Types shared by the frame sequencer
package asf_pkg;
  typedef enum logic [1:0] {ASF_IDLE, ASF_DELAY, ASF_SHIFT} asf_phase_t;
  typedef struct packed {
    asf_phase_t phase;
    logic [1:0] dly;
    logic [4:0] bitCnt;
    logic [8:0] slot;
  } asf_seq_t;
  typedef struct packed {
    logic [5:0] syncA;
    logic [5:0] syncB;
    logic txClkPrev;
    logic rxClkPrev;
    logic txFsPrev;
    logic rxFsPrev;
    logic [10:0] ctrl;
    logic [4:0] txSize;
    logic [8:0] txCount;
    logic [4:0] rxSize;
    logic [8:0] rxCount;
    logic [31:0] txMask;
    logic [31:0] rxMask;
    logic [7:0] serCtl;
    logic [1:0][31:0] txBuf;
    logic [1:0][31:0] rxBuf;
    logic [1:0][31:0] txSh;
    logic [1:0][31:0] rxSh;
    asf_seq_t tx;
    asf_seq_t rx;
    logic txAct;
    logic txPend;
    logic rxPend;
    logic [1:0] txWr;
    logic [1:0] rxRd;
    logic txFsOut;
    logic rxFsOut;
    logic [13:0] txFc;
    logic [13:0] rxFc;
    logic txFsOe_b;
    logic rxFsOe_b;
    logic [1:0] serOut;
    logic [1:0] serOe_b;
    logic ack;
    logic [31:0] dat;
  } asf_state_t;
endpackage

//--- test/asf_far_end_model.sv
// Far-end codec model: bit clocks, receive data, transmit capture
`timescale 1ns/10ps
`default_nettype none
module asf_far_end_model (
  input wire logic runTx,
  input wire logic runRx,
  output logic txBitclk,
  output logic rxBitclk,
  input wire logic fsOut,
  input wire logic [1:0] dataOut,
  input wire logic [1:0] dataOe_b,
  input wire logic rxFsOe_b,
  input wire logic [15:0] frameBits,
  output logic [1:0] dataIn,
  output logic [31:0] capWord,
  output int bitCount,
  output int syncCount,
  output int fsHighCount,
  output int lastGap,
  output logic rxFsDriven
);
  int pos;
  int gap;
  logic fsPrev;
  logic gapRun;
  initial begin
    {txBitclk, rxBitclk, fsPrev, gapRun, rxFsDriven} = 5'h0;
    dataIn = 2'h0;
    capWord = 32'h0;
    {bitCount, syncCount, fsHighCount, lastGap, gap} = {5{32'h0}};
    pos = 16;
  end
  // Clocks stop between bursts only when the bench says so
  initial begin
    #137;
    forever if (runTx) begin
      #400 txBitclk = 1'b1;
      #400 txBitclk = 1'b0;
    end else #100;
  end
  initial begin
    #311;
    forever if (runRx) begin
      #400 rxBitclk = 1'b1;
      #400 rxBitclk = 1'b0;
    end else #100;
  end
  // Sample sync and transmit data at the bit clock rising edge
  always @(posedge txBitclk) begin
    if (fsOut) fsHighCount++;
    if (fsOut && !fsPrev) syncCount++;
    fsPrev = fsOut;
    if (fsOut) begin
      pos = 0;
      gap = 0;
      gapRun = 1'b1;
    end else begin
      if (pos < 16) pos++;
      if (gapRun) gap++;
    end
    if (dataOe_b[0] === 1'b0) begin
      capWord = {capWord[30:0], dataOut[0]};
      bitCount++;
      if (gapRun) lastGap = gap;
      gapRun = 1'b0;
    end
    if (rxFsOe_b === 1'b0) rxFsDriven = 1'b1;
  end
  // Frame bits MSB first after the sync period; toggles when idle
  always @(negedge txBitclk) begin
    dataIn <= (pos < 16) ? {2{frameBits[15 - pos]}} : ~dataIn;
  end
endmodule // asf_far_end_model
`default_nettype wire

//--- test/tb_asf_frame_sequencer.sv
// Self-checking bench of the frame sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_asf_frame_sequencer;
  logic clk, rst_b, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, capWord;
  logic txBitclk, rxBitclk, txFsOut, txFsOe_b, rxFsOut, rxFsOe_b;
  logic [1:0] serIn, serOut, serOe_b;
  logic txReq, rxReq, runTx, runRx, rxFsDriven;
  logic [15:0] frameBits;
  int bitCount, syncCount, fsHighCount, lastGap, badCount, numChecks;
  asf_frame_sequencer asf_frame_sequencer_inst (.clk(clk), .rst_b(rst_b),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(datI), .dat_o(datO), .ack_o(ack), .txBitclkPin(txBitclk),
    .rxBitclkPin(rxBitclk), .txFramesyncPinIn(1'b0),
    .txFramesyncPinOut(txFsOut), .txFramesyncPinOe_b(txFsOe_b),
    .rxFramesyncPinIn(1'b0), .rxFramesyncPinOut(rxFsOut),
    .rxFramesyncPinOe_b(rxFsOe_b), .serialDataPinIn(serIn),
    .serialDataPinOut(serOut), .serialDataPinOe_b(serOe_b),
    .txDataRequest(txReq), .rxDataRequest(rxReq));
  asf_far_end_model asf_far_end_model_inst (.runTx(runTx), .runRx(runRx),
    .txBitclk(txBitclk), .rxBitclk(rxBitclk), .fsOut(txFsOut),
    .dataOut(serOut), .dataOe_b(serOe_b), .rxFsOe_b(rxFsOe_b),
    .frameBits(frameBits), .dataIn(serIn), .capWord(capWord),
    .bitCount(bitCount), .syncCount(syncCount), .fsHighCount(fsHighCount),
    .lastGap(lastGap), .rxFsDriven(rxFsDriven));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task finishTest;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Classic single cycle; holds until ack is sampled high
  task wbXfer(input logic w, input logic [7:0] a, input logic [3:0] s,
              input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    {cyc, stb, we} <= {2'h3, w};
    adr <= a;
    sel <= s;
    datI <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = datO;
    if (n >= 50) check("bus ack", 32'h1, 32'h0);
    {cyc, stb, we} <= 3'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbXfer(1'b1, a, 4'hf, d, q);
  endtask
  task rdCheck(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wbXfer(1'b0, a, 4'hf, 32'h0, q);
    check(what, exp, q);
  endtask
  task testRegs;
    logic [31:0] q;
    rdCheck("tx format reset", 8'h04, 32'h0000_001f);
    rdCheck("rx mask reset", 8'h10, 32'h0000_0001);
    rdCheck("unmapped read", 8'h40, 32'h0000_0000);
    wr(8'h18, 32'hffff_ffff);
    rdCheck("status read only", 8'h18, 32'h0000_0000);
    wr(8'h08, 32'h0180_001f);
    rdCheck("rx count 384", 8'h08, 32'h0180_001f);
    wr(8'h0c, 32'hffff_ffff);
    rdCheck("tx mask 32 slots", 8'h0c, 32'hffff_ffff);
    wbXfer(1'b1, 8'h10, 4'h1, 32'hffff_ff06, q);
    rdCheck("byte lane write", 8'h10, 32'h0000_0006);
    $display("test registers done");
  endtask
  task testBurst(input logic [1:0] d);
    int b, s, h, n;
    logic [7:0] w;
    w = 8'ha5 ^ {6'h0, d};
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h0000_0001);
    wr(8'h04, 32'h0000_0007);
    wr(8'h0c, 32'h0000_0001);
    wr(8'h00, {21'h0, 2'h0, d, 7'h0b});
    waitClk(4);
    check("tx request on enable", 32'h1, {31'h0, txReq});
    s = syncCount;
    waitClk(80);
    check("no sync before buffer", s, syncCount);
    b = bitCount;
    h = fsHighCount;
    wr(8'h20, {24'h0, w});
    n = 0;
    while (bitCount < b + 8 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    waitClk(200);
    check("bits per sync", 32'd8, bitCount - b);
    check("one sync per word", s + 1, syncCount);
    check("sync width", h + 1, fsHighCount);
    check("first bit delay", 1 + d, lastGap);
    check("word on pin", {24'h0, w}, {24'h0, capWord[7:0]});
    $display("test burst delay %0d done", d);
  endtask
  task testShared;
    int b, n;
    wr(8'h00, 32'h0);
    runRx <= 1'b0;
    frameBits <= 16'h3cc3;
    wr(8'h14, 32'h0000_002d);
    wr(8'h04, 32'h0002_0007);
    wr(8'h08, 32'h0002_0007);
    wr(8'h0c, 32'h0000_0001);
    wr(8'h10, 32'h0000_0002);
    wr(8'h20, 32'h0000_005a);
    b = bitCount;
    wr(8'h00, 32'h0000_001e);
    wr(8'h20, 32'h0000_005a);
    waitClk(1);
    check("tx request served", 32'h0, {31'h0, txReq});
    n = 0;
    while (rxReq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    runTx <= 1'b0;
    check("rx request", 32'h1, {31'h0, rxReq});
    check("tx request slot M-1", 32'h1, {31'h0, txReq});
    rdCheck("rx slot 1 data", 8'h2c, 32'h0000_00c3);
    waitClk(3);
    check("rx request cleared", 32'h0, {31'h0, rxReq});
    check("frame length", 32'h1, {31'h0, bitCount - b >= 16});
    check("slot then idle high", 32'h5aff, {16'h0, capWord[15:0]});
    check("rx sync pin released", 32'h0, {31'h0, rxFsDriven});
    $display("test shared sections done");
  endtask
  initial begin
    #2_000_000;
    badCount++;
    finishTest;
  end
  initial begin
    int i;
    rst_b = 1'b0;
    {cyc, stb, we} = 3'h0;
    adr = 8'h0;
    sel = 4'h0;
    datI = 32'h0;
    {runTx, runRx} = 2'h3;
    frameBits = 16'h0;
    badCount = 0;
    numChecks = 0;
    waitClk(5);
    rst_b <= 1'b1;
    testRegs;
    for (i = 0; i < 3; i++) begin
      testBurst(i[1:0]);
    end
    testShared;
    finishTest;
  end
endmodule // tb_asf_frame_sequencer
`default_nettype wire
